// [design/pps_pkg.sv]
// package of the protection path selector: register map, fields, modes, timing
// assumes a 100 MHz reference clock and a 32-bit APB register bus
package pps_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_CLR = 8'h0C;
  localparam logic [7:0] REG_INT_EN = 8'h10;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_REVERT_BIT = 4;
  localparam int CTRL_EXTRA_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h14;
  localparam int INT_SWITCH = 0;
  localparam int INT_TIMEOUT = 1;
  localparam int INT_PREEMPT = 2;
  localparam int INT_W = 3;
  localparam logic [2:0] INT_EN_RESET = 3'h0;
  localparam int SWITCH_TIME_US = 50000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SWITCH_CYC = SWITCH_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam logic [1:0] SEV_OK = 2'h0;
  localparam logic [1:0] SEV_DEG = 2'h1;
  localparam logic [1:0] SEV_FAIL = 2'h2;

  typedef enum logic [3:0] {
    MODE_SHARED = 4'h1,
    MODE_DEDIC = 4'h2,
    MODE_INHER = 4'h4,
    MODE_NONINT = 4'h8
  } pps_mode_e;

  function automatic logic [1:0] pps_sev(input logic fail, input logic deg);
    pps_sev = fail ? SEV_FAIL : (deg ? SEV_DEG : SEV_OK);
  endfunction
endpackage

// [design/pps_selector.sv]
// two-input, one-output protection selector with fail status forwarding
// assumes fail and degrade inputs are synchronous to clk
`timescale 1ns/100ps
module pps_selector
  import pps_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [DW-1:0] w_data,
  input wire logic w_fs,
  input wire logic w_srv,
  input wire logic w_fail,
  input wire logic w_deg,
  input wire logic [DW-1:0] p_data,
  input wire logic p_fs,
  input wire logic p_srv,
  input wire logic p_fail,
  input wire logic p_deg,
  input wire logic revertive,
  input wire logic allow,
  output logic [DW-1:0] out_data,
  output logic out_fs,
  output logic out_srv,
  output logic sel,
  output logic want,
  output logic switched
);
  logic [1:0] sev_w;
  logic [1:0] sev_p;
  logic both_clean;
  logic desired;
  logic sel_reg;
  logic sel_next;
  logic [DW-1:0] data_reg;
  logic fs_reg;
  logic srv_reg;

  assign sev_w = pps_sev(w_fail, w_deg);
  assign sev_p = pps_sev(p_fail, p_deg);
  assign both_clean = (sev_w == SEV_OK) && (sev_p == SEV_OK);
  // equal nonzero severity holds; clean paths revert only if revertive
  assign desired = (sev_w > sev_p) ? 1'b1 : (sev_p > sev_w) ? 1'b0 :
                   (both_clean && revertive) ? 1'b0 : sel_reg;
  assign want = desired != sel_reg;
  assign sel_next = allow ? desired : sel_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= 1'b0;
      data_reg <= '0;
      fs_reg <= 1'b0;
      srv_reg <= 1'b0;
      switched <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      switched <= sel_next != sel_reg;
      data_reg <= sel_reg ? p_data : w_data;
      fs_reg <= sel_reg ? p_fs : w_fs;
      srv_reg <= sel_reg ? p_srv : w_srv;
    end
  end

  assign sel = sel_reg;
  assign out_data = data_reg;
  assign out_fs = fs_reg;
  assign out_srv = srv_reg;

  chk_srv_follow: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 out_srv == ($past(sel_reg) ? $past(p_srv) : $past(w_srv)))
    else $error("forwarded fail status not from chosen input");
  chk_fast_switch: assert property (@(posedge clk) disable iff (!arst_n)
    want && allow |=> sel_reg != $past(sel_reg) && switched)
    else $error("allowed switch not taken in one cycle");
  chk_hold_equal: assert property (@(posedge clk) disable iff (!arst_n)
    (sev_w == sev_p) && !both_clean |=> $stable(sel_reg))
    else $error("selection toggled on equal conditions");
  chk_revert_work: assert property (@(posedge clk) disable iff (!arst_n)
    both_clean && allow && revertive |=> !sel_reg)
    else $error("no return to working path in revertive mode");
  cov_to_prot: cover property (@(posedge clk) disable iff (!arst_n) !sel_reg ##1 sel_reg);
  cov_to_work: cover property (@(posedge clk) disable iff (!arst_n) sel_reg ##1 !sel_reg);
endmodule // pps_selector

// [design/pps_top.sv]
// protection path selector: source bridge, sink selection, ring modes, APB registers
// assumes all traffic and indication inputs are synchronous to REF_CLK
// Summary of operation
// - shared ring: half of the payload unit groups work, the other half protect
// - shared ring: extra traffic rides protection while fault-free, dropped when needed
// - dedicated ring runs one-for-one protection on unidirectional transmission
// - dedicated ring: on defect every payload unit group loops onto protection
// - dedicated ring switches on section trail termination defects
// - dedicated ring is dual-ended; never switch at one end only
// - inherent mode: output chosen data with that input's server fail flag
// - selector has two inputs, one output, and reacts quickly to requests
// - nonintrusive mode switches on server fail, unequipped, excess errors, trace mismatch
// - nonintrusive mode never switches on signal label mismatch
// - span entry broadcasts the same signal on working and protection, except while shared ring extra traffic rides protection
// - per-path fail and degrade indications steer working or protection choice
// - a switch completes within the switch-over time, fifty milliseconds; dedicated ring waits on FAR_REQ, overrun only flags INT_TIMEOUT
// - revertive returns to working when requests end; non-revertive stays
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module pps_top
  import pps_pkg::*;
#(
  parameter int DW = 8,
  parameter int NGRP = 4,
  parameter int unsigned SWITCH_LIMIT = SWITCH_CYC
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [DW-1:0] SRC_DATA,
  input wire logic SRC_FS,
  input wire logic [DW-1:0] EXTRA_DATA,
  output logic [DW-1:0] WORK_TX_DATA,
  output logic [DW-1:0] PROT_TX_DATA,
  output logic TX_FS,
  input wire logic [DW-1:0] W_DATA,
  input wire logic W_FS,
  input wire logic W_SERVER_FAIL_FLAG,
  input wire logic W_PATH_FAIL,
  input wire logic W_PATH_DEGRADE,
  input wire logic W_UNEQUIPPED,
  input wire logic W_EXCESS_ERR,
  input wire logic W_TRACE_MISMATCH,
  input wire logic [DW-1:0] P_DATA,
  input wire logic P_FS,
  input wire logic P_SERVER_FAIL_FLAG,
  input wire logic P_PATH_FAIL,
  input wire logic P_PATH_DEGRADE,
  input wire logic P_UNEQUIPPED,
  input wire logic P_EXCESS_ERR,
  input wire logic P_TRACE_MISMATCH,
  output logic [DW-1:0] OUT_DATA,
  output logic OUT_FS,
  output logic OUT_SERVER_FAIL_FLAG,
  input wire logic FAR_REQ,
  output logic NEAR_REQ,
  output logic LOOP_ALL,
  output logic [NGRP-1:0] WORK_GRP_MASK,
  output logic IRQ
);
  localparam logic [NGRP-1:0] GRP_ALL = {NGRP{1'b1}};
  localparam logic [NGRP-1:0] GRP_HALF = GRP_ALL >> (NGRP / 2);

  logic [5:0] ctrl_reg;
  logic [INT_W-1:0] int_stat_reg;
  logic [INT_W-1:0] int_en_reg;
  logic [INT_W-1:0] int_set;
  logic [31:0] prdata_reg;
  logic [31:0] tmo_reg;
  logic [31:0] tmo_next;
  logic [DW-1:0] work_tx_reg;
  logic [DW-1:0] prot_tx_reg;
  logic tx_fs_reg;
  logic near_req_reg;
  logic loop_reg;
  logic [NGRP-1:0] mask_reg;
  logic extra_on_reg;
  logic tmo_flag_reg;

  logic [3:0] mode;
  logic revertive;
  logic extra_en;
  logic is_shared;
  logic is_dedic;
  logic is_inher;
  logic is_nonint;
  logic w_fail;
  logic w_deg;
  logic p_fail;
  logic p_deg;
  logic allow;
  logic sel;
  logic want;
  logic switched;
  logic extra_on;
  logic tmo_hit;

  // register decode
  logic hit_ctrl;
  logic hit_status;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic hit_any;
  logic wr_acc;
  logic rd_setup;
  logic [31:0] rd_mux;

  assign mode = ctrl_reg[CTRL_MODE_LSB +: 4];
  assign revertive = ctrl_reg[CTRL_REVERT_BIT];
  assign extra_en = ctrl_reg[CTRL_EXTRA_BIT];
  assign is_shared = mode == MODE_SHARED;
  assign is_dedic = mode == MODE_DEDIC;
  assign is_inher = mode == MODE_INHER;
  assign is_nonint = mode == MODE_NONINT;

  // per-mode switch criteria; ring modes use the section trail termination
  // indications, label mismatch is deliberately absent from every mode
  assign w_fail = is_inher ? W_SERVER_FAIL_FLAG :
                  is_nonint ? (W_SERVER_FAIL_FLAG | W_UNEQUIPPED | W_TRACE_MISMATCH) :
                  W_PATH_FAIL;
  assign w_deg = is_nonint ? W_EXCESS_ERR : (!is_inher && W_PATH_DEGRADE);
  assign p_fail = is_inher ? P_SERVER_FAIL_FLAG :
                  is_nonint ? (P_SERVER_FAIL_FLAG | P_UNEQUIPPED | P_TRACE_MISMATCH) :
                  P_PATH_FAIL;
  assign p_deg = is_nonint ? P_EXCESS_ERR : (!is_inher && P_PATH_DEGRADE);

  // dedicated ring moves only when the far end asks for the same switch
  assign allow = !is_dedic || FAR_REQ;

  pps_selector #(
    .DW(DW)
  ) u_sel (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .w_data(W_DATA),
    .w_fs(W_FS),
    .w_srv(W_SERVER_FAIL_FLAG),
    .w_fail(w_fail),
    .w_deg(w_deg),
    .p_data(P_DATA),
    .p_fs(P_FS),
    .p_srv(P_SERVER_FAIL_FLAG),
    .p_fail(p_fail),
    .p_deg(p_deg),
    .revertive(revertive),
    .allow(allow),
    .out_data(OUT_DATA),
    .out_fs(OUT_FS),
    .out_srv(OUT_SERVER_FAIL_FLAG),
    .sel(sel),
    .want(want),
    .switched(switched)
  );

  // extra traffic only while fault-free and nothing pending
  assign extra_on = is_shared && extra_en && !sel && !want && !w_fail && !w_deg;

  // switch-over watchdog
  assign tmo_hit = want && (tmo_reg == 32'(SWITCH_LIMIT - 1));
  assign tmo_next = !want ? 32'h0 : (tmo_hit ? tmo_reg : tmo_reg + 32'h1);

  assign int_set[INT_SWITCH] = switched;
  assign int_set[INT_TIMEOUT] = tmo_hit && !tmo_flag_reg;
  assign int_set[INT_PREEMPT] = extra_on_reg && !extra_on;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      work_tx_reg <= '0;
      prot_tx_reg <= '0;
      tx_fs_reg <= 1'b0;
    end else begin
      work_tx_reg <= SRC_DATA;
      prot_tx_reg <= extra_on ? EXTRA_DATA : SRC_DATA;
      tx_fs_reg <= SRC_FS;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      near_req_reg <= 1'b0;
      loop_reg <= 1'b0;
      mask_reg <= GRP_ALL;
      extra_on_reg <= 1'b0;
      tmo_reg <= 32'h0;
      tmo_flag_reg <= 1'b0;
    end else begin
      near_req_reg <= is_dedic && (want || sel);
      loop_reg <= is_dedic && sel;
      mask_reg <= is_shared ? GRP_HALF : GRP_ALL;
      extra_on_reg <= extra_on;
      tmo_reg <= tmo_next;
      tmo_flag_reg <= tmo_hit;
    end
  end

  assign WORK_TX_DATA = work_tx_reg;
  assign PROT_TX_DATA = prot_tx_reg;
  assign TX_FS = tx_fs_reg;
  assign NEAR_REQ = near_req_reg;
  assign LOOP_ALL = loop_reg;
  assign WORK_GRP_MASK = mask_reg;

  // APB slave, zero wait states
  assign hit_ctrl = PADDR == REG_CTRL;
  assign hit_status = PADDR == REG_STATUS;
  assign hit_stat = PADDR == REG_INT_STAT;
  assign hit_clr = PADDR == REG_INT_CLR;
  assign hit_en = PADDR == REG_INT_EN;
  assign hit_any = hit_ctrl | hit_status | hit_stat | hit_clr | hit_en;
  assign wr_acc = PSEL && PENABLE && PWRITE && hit_any;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign rd_mux = hit_ctrl ? {26'h0, ctrl_reg} :
                  hit_status ? {28'h0, loop_reg, OUT_SERVER_FAIL_FLAG, want, sel} :
                  hit_stat ? {29'h0, int_stat_reg} :
                  hit_en ? {29'h0, int_en_reg} : 32'h0;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= CTRL_RESET;
      int_en_reg <= INT_EN_RESET;
      prdata_reg <= 32'h0;
    end else begin
      if (wr_acc && hit_ctrl) begin
        ctrl_reg <= PWDATA[5:0];
      end
      if (wr_acc && hit_en) begin
        int_en_reg <= PWDATA[INT_W-1:0];
      end
      if (rd_setup) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~((wr_acc && hit_clr) ? PWDATA[INT_W-1:0] : 3'h0)) | int_set;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit_any;
  assign IRQ = |(int_stat_reg & int_en_reg);

  chk_grp_half: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_shared ##1 $stable(ctrl_reg) |-> WORK_GRP_MASK == GRP_HALF)
    else $error("shared ring group split not half and half");
  chk_extra_drop: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (want || sel || w_fail) |=> PROT_TX_DATA == $past(SRC_DATA))
    else $error("extra traffic kept while protection needed");
  chk_loop_all: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_dedic && sel |=> LOOP_ALL)
    else $error("groups not looped onto protection");
  chk_dual_end: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_dedic && !FAR_REQ |=> $stable(sel))
    else $error("single-ended switch in dedicated ring");
  chk_ring_trig: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_dedic && FAR_REQ && !sel && W_PATH_FAIL && !P_PATH_FAIL |=> sel)
    else $error("section defect did not trigger ring switch");
  chk_nim_trace: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_nonint && !sel && W_TRACE_MISMATCH && !p_fail && !p_deg |=> sel)
    else $error("trace mismatch did not switch");
  chk_bridge: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !extra_on |=> WORK_TX_DATA == PROT_TX_DATA && WORK_TX_DATA == $past(SRC_DATA))
    else $error("source not broadcast on both paths");
  chk_switch_time: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    tmo_hit && !tmo_flag_reg |=> int_stat_reg[INT_TIMEOUT])
    else $error("switch-over time overrun not flagged");
  chk_irq_level: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    switched && int_en_reg[INT_SWITCH] && !(wr_acc && hit_en) |-> ##1 IRQ)
    else $error("switch event did not raise interrupt");
  chk_nonrev_hold: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !revertive && sel && !w_fail && !w_deg && !p_fail && !p_deg |=> sel)
    else $error("non-revertive selection left protection");
  chk_mask_full: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !is_shared ##1 $stable(ctrl_reg) |-> WORK_GRP_MASK == GRP_ALL)
    else $error("group mask not full outside shared ring");
  chk_no_loop: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !is_dedic |=> !LOOP_ALL)
    else $error("loop raised outside dedicated ring");
  chk_near_req: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_dedic && want |=> NEAR_REQ)
    else $error("pending ring switch not requested from far end");
  chk_far_only: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_dedic && FAR_REQ && !want |=> $stable(sel))
    else $error("far request alone moved the selection");
  chk_extra_fill: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_shared && extra_en && !sel && !want && !w_fail && !w_deg |=> PROT_TX_DATA == $past(EXTRA_DATA))
    else $error("extra traffic not carried on idle protection");
  chk_ring_degrade: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_dedic && FAR_REQ && !sel && W_PATH_DEGRADE && !W_PATH_FAIL && !P_PATH_FAIL && !P_PATH_DEGRADE |=> sel)
    else $error("section degrade did not trigger ring switch");
  chk_inher_switch: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_inher && !sel && W_SERVER_FAIL_FLAG && !P_SERVER_FAIL_FLAG |=> sel)
    else $error("server fail did not switch inherent connection");
  chk_nim_degrade: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_nonint && !sel && W_EXCESS_ERR && !p_fail && !p_deg |=> sel)
    else $error("excess errors did not switch");
  chk_nim_unequip: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    is_nonint && !sel && W_UNEQUIPPED && !p_fail && !p_deg |=> sel)
    else $error("unequipped signal did not switch");
  chk_tx_frame: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    1'b1 |=> TX_FS == $past(SRC_FS))
    else $error("frame start not bridged");
  chk_bridge_work: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    1'b1 |=> WORK_TX_DATA == $past(SRC_DATA))
    else $error("working path not fed from source");
  chk_tmo_idle: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !want |=> tmo_reg == 32'h0)
    else $error("switch-over timer runs with nothing pending");
  // register slave and interrupt status
  chk_set_sticky: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    switched |=> int_stat_reg[INT_SWITCH])
    else $error("switch event not recorded");
  chk_clr_status: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_acc && hit_clr && PWDATA[INT_PREEMPT] && !int_set[INT_PREEMPT] |=> !int_stat_reg[INT_PREEMPT])
    else $error("status bit not cleared");
  chk_ctrl_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_acc && hit_ctrl |=> ctrl_reg == $past(PWDATA[5:0]))
    else $error("control write lost");
  chk_en_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_acc && hit_en |=> int_en_reg == $past(PWDATA[INT_W-1:0]))
    else $error("enable write lost");
  chk_ro_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_acc && hit_status |=> $stable(ctrl_reg) && $stable(int_en_reg))
    else $error("write to status changed a register");
  chk_read_ctrl: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    PSEL && !PENABLE && !PWRITE && hit_ctrl |=> PRDATA[5:0] == $past(ctrl_reg))
    else $error("control read data wrong");
  chk_err_resp: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    PSEL && PENABLE && !hit_any |-> PSLVERR && PREADY)
    else $error("unmapped access not refused");
  cov_ring_loop: cover property (@(posedge REF_CLK) disable iff (!ARST_N) is_dedic ##1 LOOP_ALL);
  cov_preempt: cover property (@(posedge REF_CLK) disable iff (!ARST_N) int_set[INT_PREEMPT]);
  cov_apb_err: cover property (@(posedge REF_CLK) disable iff (!ARST_N) PSLVERR);
endmodule // pps_top

// [tb/pps_far_model.sv]
// far-end node and upstream adaptation sink model for the protection path selector
// assumes one clock; the far end agrees to a dual-ended switch a fixed delay after the request
`timescale 1ns/100ps
module pps_far_model #(
  parameter int DELAY = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic near_req,
  input wire logic answer,
  input wire logic lop,
  input wire logic ais,
  output logic far_req,
  output logic srv_fail
);
  logic [7:0] cnt_reg;
  // server fail declared on pointer loss or alarm indication
  assign srv_fail = lop | ais;
  // far end follows the near request only while told to answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 8'h00;
      far_req <= 1'b0;
    end else if (near_req && answer) begin
      if (cnt_reg < DELAY[7:0]) cnt_reg <= cnt_reg + 8'h01;
      far_req <= (cnt_reg >= DELAY[7:0]);
    end else begin
      cnt_reg <= 8'h00;
      far_req <= 1'b0;
    end
  end
endmodule // pps_far_model

// [tb/pps_top_bench.sv]
// bench of the protection path selector: apb tasks, bridge, selection, ring and interrupt tests
// assumes pps_pkg, pps_top and pps_far_model are compiled first; 100 MHz clock
`timescale 1ns/100ps
module pps_top_bench;
  import pps_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err, irq, near_req, far_req, loop_all;
  logic src_fs, tx_fs, w_fs, p_fs, out_fs, out_sf, w_ssf, p_ssf, lop, ais, answer;
  logic [7:0] paddr, src, extra, wtx, ptx, wd, pd, od;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] wc, pc;
  logic [3:0] mask;
  int miscompares, n_compared;
  pps_top #(.DW(8), .NGRP(4), .SWITCH_LIMIT(20)) dut (
    .REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SRC_DATA(src), .SRC_FS(src_fs),
    .EXTRA_DATA(extra), .WORK_TX_DATA(wtx), .PROT_TX_DATA(ptx), .TX_FS(tx_fs), .W_DATA(wd), .W_FS(w_fs),
    .W_SERVER_FAIL_FLAG(w_ssf), .W_PATH_FAIL(wc[0]), .W_PATH_DEGRADE(wc[1]), .W_UNEQUIPPED(wc[2]),
    .W_EXCESS_ERR(wc[3]), .W_TRACE_MISMATCH(wc[4]), .P_DATA(pd), .P_FS(p_fs), .P_SERVER_FAIL_FLAG(p_ssf),
    .P_PATH_FAIL(pc[0]), .P_PATH_DEGRADE(pc[1]), .P_UNEQUIPPED(pc[2]), .P_EXCESS_ERR(pc[3]),
    .P_TRACE_MISMATCH(pc[4]), .OUT_DATA(od), .OUT_FS(out_fs), .OUT_SERVER_FAIL_FLAG(out_sf),
    .FAR_REQ(far_req), .NEAR_REQ(near_req), .LOOP_ALL(loop_all), .WORK_GRP_MASK(mask), .IRQ(irq));
  pps_far_model #(.DELAY(3)) far (.clk(clk), .arst_n(arst_n), .near_req(near_req), .answer(answer),
    .lop(lop), .ais(ais), .far_req(far_req), .srv_fail(w_ssf));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, src, src_fs, extra} = '0;
    {wd, pd, w_fs, p_fs, p_ssf, wc, pc} = {8'hA5, 8'h5A, 3'h2, 10'h000};
    {lop, ais, answer} = 3'h1;
    {miscompares, n_compared} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h14);
    check(pready, 32'h1);
    apb(1'b0, REG_INT_EN, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check(err, 32'h1);
    check(mask, 32'hF);
    @(posedge clk);
    {src, src_fs} <= {8'h3C, 1'b1};
    tick(2);
    check(wtx, 32'h3C);
    check(ptx, 32'h3C);
    check(tx_fs, 32'h1);
    $display("test reset and bridge done");
    @(posedge clk);
    lop <= 1'b1;
    tick(2);
    check(od, 32'h5A);
    check(out_sf, 32'h0);
    check(out_fs, 32'h1);
    @(posedge clk);
    p_ssf <= 1'b1;
    tick(3);
    check(od, 32'h5A);
    check(out_sf, 32'h1);
    @(posedge clk);
    {lop, p_ssf} <= 2'b00;
    tick(3);
    check(od, 32'hA5);
    @(posedge clk);
    ais <= 1'b1;
    tick(2);
    check(od, 32'h5A);
    @(posedge clk);
    ais <= 1'b0;
    tick(3);
    check(od, 32'hA5);
    apb(1'b1, REG_CTRL, 32'h04);
    @(posedge clk);
    ais <= 1'b1;
    tick(2);
    @(posedge clk);
    ais <= 1'b0;
    tick(3);
    check(od, 32'h5A);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd[0], 32'h1);
    $display("test inherent done");
    apb(1'b1, REG_CTRL, 32'h18);
    tick(3);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      wc[i] <= 1'b1;
      tick(2);
      check(od, (i > 1) ? 32'h5A : 32'hA5);
      @(posedge clk);
      wc[i] <= 1'b0;
      tick(3);
    end
    @(posedge clk);
    {wc[2], pc[4]} <= 2'b11;
    tick(3);
    check(od, 32'hA5);
    @(posedge clk);
    {wc[2], pc[4]} <= 2'b00;
    $display("test nonintrusive done");
    apb(1'b1, REG_CTRL, 32'h31);
    apb(1'b1, REG_INT_CLR, 32'h7);
    apb(1'b1, REG_INT_EN, 32'h7);
    @(posedge clk);
    extra <= 8'hE7;
    tick(2);
    check(mask, 32'h3);
    check(ptx, 32'hE7);
    @(posedge clk);
    wc[0] <= 1'b1;
    tick(2);
    check(ptx, 32'h3C);
    check(od, 32'h5A);
    check(irq, 32'h1);
    apb(1'b0, REG_INT_STAT, 32'h0);
    check(rd, 32'h5);
    apb(1'b1, REG_INT_EN, 32'h0);
    check(irq, 32'h0);
    @(posedge clk);
    wc[0] <= 1'b0;
    tick(4);
    apb(1'b1, REG_INT_CLR, 32'h7);
    apb(1'b0, REG_INT_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, REG_INT_EN, 32'h7);
    check(irq, 32'h0);
    $display("test shared ring done");
    apb(1'b1, REG_CTRL, 32'h12);
    @(posedge clk);
    {answer, wc[0]} <= 2'b01;
    tick(2);
    check(near_req, 32'h1);
    check(mask, 32'hF);
    tick(25);
    check(loop_all, 32'h0);
    check(od, 32'hA5);
    apb(1'b0, REG_INT_STAT, 32'h0);
    check(rd[1], 32'h1);
    @(posedge clk);
    answer <= 1'b1;
    for (int k = 0; k < 20 && loop_all !== 1'b1; k++) tick(1);
    check(loop_all, 32'h1);
    tick(2);
    check(od, 32'h5A);
    @(posedge clk);
    wc[0] <= 1'b0;
    for (int k = 0; k < 20 && loop_all !== 1'b0; k++) tick(1);
    tick(2);
    check(od, 32'hA5);
    $display("test dedicated ring done");
    stop_test;
  end
endmodule // pps_top_bench
